// ===== include/banked_data_memory_map.vh
`ifndef BANKED_DATA_MEMORY_MAP_VH
`define BANKED_DATA_MEMORY_MAP_VH

// Common-region locations (5-bit file addresses)
`define LOC_INDIRECT        5'h00
`define LOC_TIMER_A         5'h01
`define LOC_PROG_COUNTER    5'h02
`define LOC_STATUS          5'h03
`define LOC_BANK_SELECT     5'h04
`define LOC_PORT_A          5'h05
`define LOC_PORT_B          5'h06
`define LOC_PORT_C          5'h07

// APB byte addresses of the debug/host window
`define APB_FILE_BASE       12'h000
`define APB_CTRL            12'h400
`define APB_STATUS_VIEW     12'h404
`define APB_BANK_VIEW       12'h408
`define APB_PAGE_VIEW       12'h40c

// Bank-select fields
`define BSEL_BLOCK_HI       7
`define BSEL_BLOCK_LO       5
`define BSEL_REGION_BIT     4
`define BSEL_BYTE_HI        3

// Status fields
`define ST_PAGE_SPARE       7
`define ST_PAGE_HI          6
`define ST_PAGE_LO          5
`define ST_TMRB_OVF         4
`define ST_IRQ_DIS          3
`define ST_ZERO             2
`define ST_NIBBLE_CARRY     1
`define ST_CARRY            0

// Reset values
`define STATUS_RESET        8'h08
`define BSEL_RESET          8'h00

// Program page base addresses
`define PAGE_BASE_0         11'h000
`define PAGE_BASE_1         11'h200
`define PAGE_BASE_2         11'h400
`define PAGE_BASE_3         11'h600

`endif

// ===== verilog/data_byte_store.v
`timescale 1ns/1ps
// Physical byte storage: common and per-block general purpose bytes
module data_byte_store #(
	parameter DEPTH = 136,
	parameter AW    = 8
) (
	input  wire          pclk,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [7:0]    wdata,
	input  wire [AW-1:0] raddr,
	output wire [7:0]    rdata
);
	reg [7:0] mem [0:DEPTH-1];

	// Combinational read so a write is seen on the next cycle
	assign rdata = mem[raddr];

	always @(posedge pclk) begin
		if (we)
			mem[waddr] <= wdata;
	end
endmodule

// ===== verilog/banked_data_memory_status.v
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "banked_data_memory_map.vh"
// Contract
// - 144 readable/writable data bytes: 16 common, 128 block dependent. Here writes to the timer A location are ignored.
// - Common order: indirect, timer A, PC, status, bank select, ports A-C, 8 GENERAL_PURPOSE_BYTES.
// - Bank-select bits 7..5 choose one of eight 32-location blocks.
// - Locations 0x00-0x0F map to the same storage in every block.
// - Upper 16 locations per block are private storage.
// - Timer A location returns low byte if bit5 zero, high byte if one.
// - Bank-select bit4 picks common lower or block upper region for indirect.
// - Bank-select bits 3..0 pick the byte within the region.
// - Bank-select register is fully readable and writable.
// - Status writes cannot reach Z, DC, C when instruction updates flags.
// - Status layout page/overflow/disable/flags; reset 7..4 clear, bit3 set.
// - Low page bits select 512-word program range 0x000/0x200/0x400/0x600.
// - Spare page bit has no effect but keeps its value.
// - Timer B overflow flag reads one after overflow, zero after clear.
// - Indirect port accesses location addressed by bank-select register.
// - Interrupt disable bit: zero enables, one disables globally.
// - Zero flag set on zero result; nibble carry on carry from bit3.
module banked_data_memory_status (
	input  wire        pclk,
	input  wire        presetn,
	// Core datapath side
	input  wire        core_rd,
	input  wire        core_wr,
	input  wire [4:0]  core_addr,
	input  wire [7:0]  core_wdata,
	output reg  [7:0]  core_rdata_q,
	input  wire        flags_update,
	input  wire [7:0]  alu_result,
	input  wire        alu_carry,
	input  wire        alu_nibble_carry,
	input  wire        alu_flags_valid,
	input  wire [15:0] first_timer_count,
	input  wire [7:0]  pc_low,
	input  wire [7:0]  first_port_latch,
	input  wire [7:0]  peripheral_port_latch,
	input  wire [7:0]  third_port_latch,
	input  wire        timer_b_overflow,
	output reg         global_irq_disable_q,
	output reg  [10:0] prog_page_base_q,
	output reg         prog_page_is_ram_q,
	output reg         port_wr_q,
	output reg  [1:0]  port_sel_q,
	output reg  [7:0]  port_wdata_q,
	output reg         pc_wr_q,
	output reg  [7:0]  pc_wdata_q,
	// APB
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_q,
	output reg         pready_q,
	output reg         pslverr_q
);
	localparam ST_IDLE = 1'b0;
	localparam ST_DONE = 1'b1;

	reg  [7:0]  status_q;
	reg  [7:0]  bsel_q;
	reg         core_hold_q;
	reg         apb_state_q;
	wire [7:0]  mem_rdata;
	reg         mem_we;
	reg  [7:0]  mem_waddr;
	reg  [7:0]  mem_wdata;
	reg  [7:0]  mem_raddr;

	// Map an 8-bit logical data address to a physical byte: 0..7 common GENERAL_PURPOSE_BYTES,
	// 8..135 block private; bit 8 marks special locations
	function [8:0] phys_map;
		input [7:0] la;
		begin
			if (!la[`BSEL_REGION_BIT]) begin
				phys_map = {~la[3], 5'h00, la[2:0]};
			end else begin
				phys_map = {1'b0, 8'h08 + {1'b0, la[7:5], la[3:0]}};
			end
		end
	endfunction

	// Logical address seen by the core
	function [7:0] logical_addr;
		input [4:0] fa;
		input [7:0] bs;
		begin
			if (fa == `LOC_INDIRECT)
				logical_addr = bs;
			else
				logical_addr = {bs[`BSEL_BLOCK_HI:`BSEL_BLOCK_LO], fa};
		end
	endfunction

	function [7:0] sfr_read;
		input [2:0] idx;
		begin
			case (idx)
				3'd1: sfr_read = bsel_q[`BSEL_BLOCK_LO] ? first_timer_count[15:8]
					: first_timer_count[7:0];
				3'd2: sfr_read = pc_low;
				3'd3: sfr_read = status_q;
				3'd4: sfr_read = bsel_q;
				3'd5: sfr_read = first_port_latch;
				3'd6: sfr_read = peripheral_port_latch;
				3'd7: sfr_read = third_port_latch;
				default: sfr_read = 8'h00; // Indirect through itself reads zero
			endcase
		end
	endfunction

	wire [7:0] core_la  = logical_addr(core_addr, bsel_q);
	wire [8:0] core_pa  = phys_map(core_la);
	wire       core_sfr = core_pa[8] & (core_la[3] == 1'b0);
	wire       apb_file = (paddr[11:10] == 2'b00);
	wire [7:0] apb_la   = paddr[9:2];
	wire [8:0] apb_pa   = phys_map(apb_la);
	wire       apb_sfr  = apb_pa[8] & (apb_la[3] == 1'b0);
	wire       apb_acc  = psel & penable & (apb_state_q == ST_IDLE) & ~core_hold_q;
	wire       apb_wr   = apb_acc & pwrite;

	// Status flags from the ALU
	wire       alu_zero = (alu_result == 8'h00);

	data_byte_store #(
		.DEPTH (136),
		.AW    (8)
	) u_store (
		.pclk  (pclk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// Core has priority for the single storage port; APB waits out the core access and one more cycle
	always @* begin
		mem_we    = 1'b0;
		mem_waddr = 8'h00;
		mem_wdata = 8'h00;
		mem_raddr = core_pa[7:0];
		if (core_wr && !core_sfr) begin
			mem_we    = 1'b1;
			mem_waddr = core_pa[7:0];
			mem_wdata = core_wdata;
		end else if (!core_wr && !core_rd && apb_file && !apb_sfr) begin
			mem_raddr = apb_pa[7:0];
			mem_we    = apb_wr;
			mem_waddr = apb_pa[7:0];
			mem_wdata = pwdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			core_hold_q <= 1'b0;
		else
			core_hold_q <= core_rd | core_wr;
	end

	wire       core_sfr_wr = core_wr & core_sfr;
	wire [2:0] core_sfr_ix = core_la[2:0];
	wire       apb_sfr_wr  = apb_wr & apb_file & apb_sfr & ~core_wr & ~core_rd;
	wire [2:0] apb_sfr_ix  = apb_la[2:0];

	// Timer B ticks from the slow clock: two stages, then one rising edge,
	// so a tick that stays high does not set the flag again after a clear
	reg        ovf_meta_q;
	reg        ovf_sync_q;
	reg        ovf_prev_q;
	wire       ovf_event = ovf_sync_q & ~ovf_prev_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_meta_q <= 1'b0;
			ovf_sync_q <= 1'b0;
			ovf_prev_q <= 1'b0;
		end else begin
			ovf_meta_q <= timer_b_overflow;
			ovf_sync_q <= ovf_meta_q;
			ovf_prev_q <= ovf_sync_q;
		end
	end

	// Status register
	reg [7:0] status_d;
	always @* begin
		status_d = status_q;
		if (core_sfr_wr && core_sfr_ix == `LOC_STATUS) begin
			status_d = core_wdata;
			if (flags_update)
				status_d[`ST_ZERO:`ST_CARRY] = status_q[`ST_ZERO:`ST_CARRY];
		end else if (apb_sfr_wr && apb_sfr_ix == `LOC_STATUS) begin
			status_d = pwdata[7:0];
		end
		if (alu_flags_valid) begin
			status_d[`ST_ZERO]         = alu_zero;
			status_d[`ST_NIBBLE_CARRY] = alu_nibble_carry;
			status_d[`ST_CARRY]        = alu_carry;
		end
		if (ovf_event)
			status_d[`ST_TMRB_OVF] = 1'b1;
	end

	// Flags 2..0 have no defined reset; zero is used
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= `STATUS_RESET;
			bsel_q   <= `BSEL_RESET;
		end else begin
			status_q <= status_d;
			if (core_sfr_wr && core_sfr_ix == `LOC_BANK_SELECT)
				bsel_q <= core_wdata;
			else if (apb_sfr_wr && apb_sfr_ix == `LOC_BANK_SELECT)
				bsel_q <= pwdata[7:0];
		end
	end

	// Core read data and derived outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_rdata_q         <= 8'h00;
			global_irq_disable_q <= 1'b1;
			prog_page_base_q     <= `PAGE_BASE_0;
			prog_page_is_ram_q   <= 1'b0;
			port_wr_q            <= 1'b0;
			port_sel_q           <= 2'd0;
			port_wdata_q         <= 8'h00;
			pc_wr_q              <= 1'b0;
			pc_wdata_q           <= 8'h00;
		end else begin
			if (core_rd)
				core_rdata_q <= core_sfr ? sfr_read(core_sfr_ix) : mem_rdata;
			global_irq_disable_q <= status_d[`ST_IRQ_DIS];
			case (status_d[`ST_PAGE_HI:`ST_PAGE_LO])
				2'b00: prog_page_base_q <= `PAGE_BASE_0;
				2'b01: prog_page_base_q <= `PAGE_BASE_1;
				2'b10: prog_page_base_q <= `PAGE_BASE_2;
				default: prog_page_base_q <= `PAGE_BASE_3;
			endcase
			prog_page_is_ram_q <= (status_d[`ST_PAGE_HI:`ST_PAGE_LO] == 2'b01);
			port_wr_q    <= core_sfr_wr && (core_sfr_ix >= `LOC_PORT_A);
			port_sel_q   <= core_sfr_ix[1:0] - 2'd1;
			port_wdata_q <= core_wdata;
			pc_wr_q      <= core_sfr_wr && (core_sfr_ix == `LOC_PROG_COUNTER);
			pc_wdata_q   <= core_wdata;
		end
	end

	// APB slave: answers one cycle after the access phase starts, waits
	// while the core owns the storage port
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_state_q <= ST_IDLE;
			pready_q    <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			pslverr_q   <= 1'b0;
		end else begin
			case (apb_state_q)
				ST_IDLE: begin
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
					if (psel && penable && !core_hold_q && !core_rd && !core_wr) begin
						apb_state_q <= ST_DONE;
						pready_q    <= 1'b1;
						prdata_q    <= 32'h0000_0000;
						if (apb_file && apb_sfr)
							prdata_q <= {24'h000000, sfr_read(apb_sfr_ix)};
						else if (apb_file)
							prdata_q <= {24'h000000, mem_rdata};
						else if (paddr == `APB_CTRL)
							prdata_q <= {24'h000000, bsel_q};
						else if (paddr == `APB_STATUS_VIEW)
							prdata_q <= {24'h000000, status_q};
						else if (paddr == `APB_BANK_VIEW)
							prdata_q <= {29'h0, bsel_q[`BSEL_BLOCK_HI:`BSEL_BLOCK_LO]};
						else if (paddr == `APB_PAGE_VIEW)
							prdata_q <= {20'h00000, prog_page_is_ram_q, prog_page_base_q};
						else
							pslverr_q <= 1'b1;
					end
				end
				ST_DONE: begin
					apb_state_q <= ST_IDLE;
					pready_q    <= 1'b0;
					pslverr_q   <= 1'b0;
				end
				default: apb_state_q <= ST_IDLE;
			endcase
		end
	end
endmodule

// ===== sim/banked_chk_chk.sv
`timescale 1ns/1ps
module banked_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        core_rd,
	input wire        core_wr,
	input wire [4:0]  core_addr,
	input wire [7:0]  core_wdata,
	input wire [7:0]  core_rdata_q,
	input wire [7:0]  pc_low,
	input wire [7:0]  first_port_latch,
	input wire [7:0]  peripheral_port_latch,
	input wire [7:0]  third_port_latch,
	input wire        global_irq_disable_q,
	input wire [10:0] prog_page_base_q,
	input wire        prog_page_is_ram_q,
	input wire        port_wr_q,
	input wire [1:0]  port_sel_q,
	input wire [7:0]  port_wdata_q,
	input wire        pc_wr_q,
	input wire [7:0]  pc_wdata_q,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire        pready_q,
	input wire        pslverr_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [7:0] src = (core_addr == 5'h02) ? pc_low : (core_addr == 5'h05) ? first_port_latch :
		(core_addr == 5'h06) ? peripheral_port_latch : third_port_latch;
	wire       wr_any = core_wr || (psel && penable && pwrite);
	a_port_wr_pulse: assert property (core_wr && core_addr inside {5'h05, 5'h06, 5'h07} |=>
		port_wr_q && port_sel_q == $past(core_addr) - 5'h05 && port_wdata_q == $past(core_wdata))
		else $error("port write not forwarded");
	a_pc_wr_pulse: assert property (core_wr && core_addr == 5'h02 |=>
		pc_wr_q && pc_wdata_q == $past(core_wdata)) else $error("pc write not forwarded");
	a_rdata_source: assert property (core_rd && core_addr inside {5'h02, 5'h05, 5'h06, 5'h07} |=>
		core_rdata_q == $past(src)) else $error("read source wrong");
	a_page_decode: assert property (prog_page_base_q[8:0] == 9'h000 &&
		prog_page_is_ram_q == (prog_page_base_q == 11'h200)) else $error("page decode wrong");
	a_cfg_cause: assert property ($changed({global_irq_disable_q, prog_page_base_q}) |->
		$past(wr_any) || $past(wr_any, 2)) else $error("config changed without write");
	a_pready_pulse: assert property (pready_q |=> !pready_q) else $error("pready too long");
	a_pready_access: assert property (pready_q |-> $past(psel && penable) &&
		$past(!core_rd && !core_wr)) else $error("stray pready");
	a_err_map: assert property (pready_q && paddr[1:0] == 2'b00 |-> pslverr_q == (paddr >= 12'h410))
		else $error("slave error wrong");
	c_port_wr: cover property (port_wr_q);
	c_apb_err: cover property (pready_q && pslverr_q);
	c_page_ram: cover property (prog_page_is_ram_q);
endmodule
bind banked_data_memory_status banked_chk u_chk (.pclk(pclk), .presetn(presetn),
	.core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
	.core_rdata_q(core_rdata_q), .pc_low(pc_low), .first_port_latch(first_port_latch),
	.peripheral_port_latch(peripheral_port_latch), .third_port_latch(third_port_latch),
	.global_irq_disable_q(global_irq_disable_q), .prog_page_base_q(prog_page_base_q),
	.prog_page_is_ram_q(prog_page_is_ram_q), .port_wr_q(port_wr_q), .port_sel_q(port_sel_q),
	.port_wdata_q(port_wdata_q), .pc_wr_q(pc_wr_q), .pc_wdata_q(pc_wdata_q), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready_q(pready_q),
	.pslverr_q(pslverr_q));

// ===== sim/core_model.sv
`timescale 1ns/1ps
module core_model (
	input  wire       pclk,
	input  wire [7:0] core_rdata_q,
	output reg        core_rd,
	output reg        core_wr,
	output reg  [4:0] core_addr,
	output reg  [7:0] core_wdata,
	output reg        flags_update,
	output reg  [7:0] alu_result,
	output reg        alu_carry,
	output reg        alu_nibble_carry,
	output reg        alu_flags_valid
);
	initial {core_rd, core_wr, core_addr, core_wdata, flags_update} = 16'h0000;
	initial {alu_result, alu_carry, alu_nibble_carry, alu_flags_valid} = 11'h000;
	// Flag-updating writes only when a scenario asks for them
	task wr(input [4:0] a, input [7:0] d, input fu, input [7:0] r, input c, input nc);
		begin
			@(posedge pclk);
			core_wr <= 1'b1;
			core_addr <= a;
			core_wdata <= d;
			flags_update <= fu;
			alu_flags_valid <= fu;
			{alu_result, alu_carry, alu_nibble_carry} <= {r, c, nc};
			@(posedge pclk);
			{core_wr, flags_update, alu_flags_valid} <= 3'b000;
			core_wdata <= ~d;
		end
	endtask
	task rd(input [4:0] a, output [7:0] d);
		begin
			@(posedge pclk);
			core_rd <= 1'b1;
			core_addr <= a;
			@(posedge pclk);
			core_rd <= 1'b0;
			@(negedge pclk);
			d = core_rdata_q;
		end
	endtask
endmodule

// ===== sim/banked_data_memory_status_test.sv
`timescale 1ns/1ps
module banked_data_memory_status_test;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         timer_b_overflow = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h00000000;
	wire        core_rd, core_wr, flags_update, alu_carry, alu_nibble_carry, alu_flags_valid;
	wire [4:0]  core_addr;
	wire [7:0]  core_wdata, alu_result, core_rdata_q, port_wdata_q, pc_wdata_q;
	wire        global_irq_disable_q, prog_page_is_ram_q, port_wr_q, pc_wr_q;
	wire        pready_q, pslverr_q;
	wire [10:0] prog_page_base_q;
	wire [1:0]  port_sel_q;
	wire [31:0] prdata_q;
	integer     num_errors = 0;
	integer     tests_run = 0;
	integer     i;
	always #5 pclk = ~pclk;
	core_model core (.pclk(pclk), .core_rdata_q(core_rdata_q), .core_rd(core_rd),
		.core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
		.flags_update(flags_update), .alu_result(alu_result), .alu_carry(alu_carry),
		.alu_nibble_carry(alu_nibble_carry), .alu_flags_valid(alu_flags_valid));
	banked_data_memory_status DUT (.pclk(pclk), .presetn(presetn), .core_rd(core_rd),
		.core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
		.core_rdata_q(core_rdata_q), .flags_update(flags_update), .alu_result(alu_result),
		.alu_carry(alu_carry), .alu_nibble_carry(alu_nibble_carry),
		.alu_flags_valid(alu_flags_valid), .first_timer_count(16'h5a3c), .pc_low(8'h42),
		.first_port_latch(8'h15), .peripheral_port_latch(8'h26), .third_port_latch(8'h37),
		.timer_b_overflow(timer_b_overflow), .global_irq_disable_q(global_irq_disable_q),
		.prog_page_base_q(prog_page_base_q), .prog_page_is_ram_q(prog_page_is_ram_q),
		.port_wr_q(port_wr_q), .port_sel_q(port_sel_q), .port_wdata_q(port_wdata_q),
		.pc_wr_q(pc_wr_q), .pc_wdata_q(pc_wdata_q), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q));
	task summarize;
		begin
			$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
			if (num_errors == 0 && tests_run > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("Error at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask
	// Data is only compared when no slave error is expected
	task apb(input w, input [11:0] a, input [31:0] d, input [31:0] exp, input err);
		integer n;
		begin
			@(posedge pclk);
			{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready_q !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge pclk);
			end
			if (n >= 20) begin
				num_errors = num_errors + 1;
				summarize;
			end else begin
				check(pslverr_q, err);
				if (!w && !err)
					check(prdata_q, exp);
				{psel, penable} <= 2'b00;
				pwdata <= ~d;
			end
		end
	endtask
	task cw(input [4:0] a, input [7:0] d);
		core.wr(a, d, 1'b0, 8'h00, 1'b0, 1'b0);
	endtask
	task cchk(input [4:0] a, input [7:0] exp);
		reg [7:0] d;
		begin
			core.rd(a, d);
			check(d, exp);
		end
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h404, 0, 32'h08, 1'b0);
		apb(1'b0, 12'h400, 0, 32'h00, 1'b0);
		check(global_irq_disable_q, 1);
		cw(5'h04, 8'h20);
		cw(5'h10, 8'ha1);
		cw(5'h04, 8'h40);
		cw(5'h10, 8'hb2);
		cw(5'h08, 8'hc8);
		cchk(5'h10, 8'hb2);
		cw(5'h04, 8'h20);
		cchk(5'h10, 8'ha1);
		cchk(5'h08, 8'hc8);
		cchk(5'h04, 8'h20);
		cchk(5'h01, 8'h5a);
		apb(1'b0, 12'h408, 0, 32'h01, 1'b0);
		apb(1'b0, 12'h140, 0, 32'hb2, 1'b0);
		cw(5'h04, 8'h30);
		cchk(5'h00, 8'ha1);
		cw(5'h04, 8'h08);
		cchk(5'h00, 8'hc8);
		cw(5'h04, 8'h00);
		cchk(5'h01, 8'h3c);
		apb(1'b1, 12'h02c, 32'h5c, 0, 1'b0);
		cchk(5'h0b, 8'h5c);
		for (i = 0; i < 4; i = i + 1)
			cchk((i == 0) ? 5'h02 : i + 4, (i == 0) ? 8'h42 : 8'h15 + 8'h11 * (i - 1));
		cw(5'h05, 8'h99);
		@(negedge pclk);
		check({port_wr_q, port_sel_q, port_wdata_q}, {1'b1, 2'h0, 8'h99});
		cw(5'h02, 8'h77);
		@(negedge pclk);
		check({port_wr_q, pc_wr_q, pc_wdata_q}, {1'b0, 1'b1, 8'h77});
		for (i = 0; i < 4; i = i + 1) begin
			cw(5'h03, {1'b1, i[1:0], 5'h08});
			apb(1'b0, 12'h404, 0, {1'b1, i[1:0], 5'h08}, 1'b0);
			check(prog_page_base_q, i * 11'h200);
			check(prog_page_is_ram_q, i == 1);
		end
		cw(5'h03, 8'h00);
		apb(1'b0, 12'h404, 0, 32'h00, 1'b0);
		check(global_irq_disable_q, 0);
		core.wr(5'h03, 8'h00, 1'b1, 8'h00, 1'b1, 1'b1);
		apb(1'b0, 12'h404, 0, 32'h07, 1'b0);
		core.wr(5'h03, 8'h07, 1'b1, 8'h01, 1'b0, 1'b0);
		apb(1'b0, 12'h404, 0, 32'h00, 1'b0);
		@(posedge pclk);
		timer_b_overflow <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h404, 0, 32'h10, 1'b0);
		cw(5'h03, 8'h00);
		apb(1'b0, 12'h404, 0, 32'h00, 1'b0);
		timer_b_overflow <= 1'b0;
		apb(1'b0, 12'h410, 0, 0, 1'b1);
		summarize;
	end
endmodule
